//--- core/utrovl_pkg.sv
/*
  Shared constants for the under-temperature reaction and input-overvoltage limit block.
  Assumes a 25 MHz core clock and a two-page management port.
*/
package utrovl_pkg;

  // Core clock and retry timing.
  localparam int CLK_HZ        = 25_000_000;
  localparam int RETRY_STEP_MS = 25;
  localparam int RETRY_LONG_MS = 175;
  localparam int RETRY_STEP_CYC = RETRY_STEP_MS * (CLK_HZ / 1000);
  localparam logic [2:0] RETRY_LONG_UNITS = 3'(RETRY_LONG_MS / RETRY_STEP_MS);

  // Management port.
  localparam logic [6:0] SLAVE_ADDR = 7'h40;  // Arbitrary value.
  localparam int PAGES = 2;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Command codes.
  localparam logic [7:0] CMD_PAGE     = 8'h00;
  localparam logic [7:0] CMD_CLEAR    = 8'h03;
  localparam logic [7:0] CMD_UT_REACT = 8'h54;
  localparam logic [7:0] CMD_VIN_OV   = 8'h55;
  localparam logic [7:0] CMD_STATUS   = 8'hd0;
  localparam logic [7:0] RD_UNMAPPED  = 8'hff;

  // Reset values.
  localparam logic [7:0]  UT_REACT_RST = 8'h84;
  localparam logic [15:0] VIN_OV_RST   = 16'h0640;

  // Reaction byte fields.
  localparam int REACT_HI = 7;
  localparam int REACT_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;
  localparam logic [1:0] REACT_CONTINUE = 2'h0;
  localparam logic [1:0] REACT_DISABLE  = 2'h2;
  localparam logic [2:0] RETRY_ENDLESS  = 3'h7;
  localparam logic [2:0] DELAY_LONG     = 3'h7;

  // Status byte bits.
  localparam int STAT_UT = 0;
  localparam int STAT_OV = 1;

  // Clearing hysteresis in degrees Celsius.
  localparam logic signed [16:0] UT_HYST_DEGC = 17'sh00005;

  typedef enum logic [1:0] {
    RS_RUN   = 2'b00,
    RS_LATCH = 2'b01,
    RS_WAIT  = 2'b10,
    RS_OFF   = 2'b11
  } utrovl_rail_e;

  typedef enum logic [2:0] {
    BS_IDLE = 3'b000,
    BS_RX   = 3'b001,
    BS_ACK  = 3'b010,
    BS_TX   = 3'b011,
    BS_MACK = 3'b100
  } utrovl_bus_e;

endpackage

//--- core/utrovl_retry.sv
/*
  Per-page under-temperature detector with hysteresis and the fault reaction
  and retry sequencer that gates the rail.
  Assumes measurements and rail controls come from logic on sys_clk.
*/
`timescale 1ns/1ns
module utrovl_retry #(
  parameter int STEP_CYC = utrovl_pkg::RETRY_STEP_CYC
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               arst_n,
  // Configuration
  input  wire logic [7:0]         reaction,
  input  wire logic signed [15:0] ut_limit,
  // Measurement and rail control
  input  wire logic signed [15:0] stage_temp,
  input  wire logic               rail_on,
  input  wire logic               bias_ok,
  input  wire logic               other_fault,
  // Results
  output logic                    out_en_ff,
  output logic                    ut_active_ff
);

  utrovl_pkg::utrovl_rail_e state_ff;
  utrovl_pkg::utrovl_rail_e nxt_state;
  logic [23:0]              step_ff;
  logic [23:0]              nxt_step;
  logic [2:0]               units_ff;
  logic [2:0]               nxt_units;
  logic                     nxt_out_en;
  logic                     nxt_ut_active;
  logic signed [16:0]       clear_lvl;
  logic                     rail_ok;
  logic                     trip;
  logic [1:0]               react_f;
  logic [2:0]               retry_f;
  logic [2:0]               delay_f;
  logic [2:0]               delay_units;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    react_f = reaction[utrovl_pkg::REACT_HI:utrovl_pkg::REACT_LO];
    retry_f = reaction[utrovl_pkg::RETRY_HI:utrovl_pkg::RETRY_LO];
    delay_f = reaction[utrovl_pkg::DELAY_HI:utrovl_pkg::DELAY_LO];
    // Code seven is the long delay, the others count whole steps.
    delay_units = (delay_f == utrovl_pkg::DELAY_LONG) ? utrovl_pkg::RETRY_LONG_UNITS
                                                       : delay_f;
    clear_lvl = $signed({ut_limit[15], ut_limit}) + utrovl_pkg::UT_HYST_DEGC;
    nxt_ut_active = ut_active_ff;
    if (!ut_active_ff && (stage_temp < ut_limit)) begin
      nxt_ut_active = 1'b1;
    end else if (ut_active_ff && ($signed({stage_temp[15], stage_temp}) >= clear_lvl)) begin
      nxt_ut_active = 1'b0;
    end
    rail_ok = rail_on && bias_ok && !other_fault;
    // Unsupported reaction codes keep regulating.
    trip = ut_active_ff && (react_f == utrovl_pkg::REACT_DISABLE);
    nxt_state = state_ff;
    nxt_step  = step_ff;
    nxt_units = units_ff;
    unique case (state_ff)
      utrovl_pkg::RS_RUN: begin
        if (!rail_ok) begin
          nxt_state = utrovl_pkg::RS_OFF;
        end else if (trip) begin
          if (retry_f == utrovl_pkg::RETRY_ENDLESS) begin
            nxt_state = utrovl_pkg::RS_WAIT;
            nxt_step  = '0;
            nxt_units = delay_units;
          end else begin
            nxt_state = utrovl_pkg::RS_LATCH;
          end
        end
      end
      utrovl_pkg::RS_LATCH: begin
        if (!rail_ok) begin
          nxt_state = utrovl_pkg::RS_OFF;
        end
      end
      utrovl_pkg::RS_WAIT: begin
        if (!rail_ok) begin
          nxt_state = utrovl_pkg::RS_OFF;
        end else if (units_ff == 3'h0) begin
          nxt_state = utrovl_pkg::RS_RUN;
        end else if (step_ff == 24'(STEP_CYC - 1)) begin
          nxt_step  = '0;
          nxt_units = units_ff - 3'h1;
        end else begin
          nxt_step = step_ff + 24'h000001;
        end
      end
      utrovl_pkg::RS_OFF: begin
        if (rail_ok) begin
          nxt_state = utrovl_pkg::RS_RUN;
        end
      end
    endcase
    nxt_out_en = (nxt_state == utrovl_pkg::RS_RUN);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff     <= utrovl_pkg::RS_OFF;
      step_ff      <= '0;
      units_ff     <= 3'h0;
      out_en_ff    <= 1'b0;
      ut_active_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      step_ff      <= nxt_step;
      units_ff     <= nxt_units;
      out_en_ff    <= nxt_out_en;
      ut_active_ff <= nxt_ut_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_tripped_latch;
    state_ff == utrovl_pkg::RS_RUN && rail_ok && trip && retry_f != utrovl_pkg::RETRY_ENDLESS;
  endsequence
  sequence s_held_off;
    !out_en_ff [*3];
  endsequence

  property p_latch_off;
    s_tripped_latch ##1 (rail_ok && $stable(reaction)) [*2] |-> s_held_off;
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("latched rail came back on");

  property p_continue;
    state_ff == utrovl_pkg::RS_RUN && rail_ok && react_f == utrovl_pkg::REACT_CONTINUE
      |=> out_en_ff;
  endproperty
  a_continue: assert property (p_continue) else $error("continue mode dropped rail");

  property p_trip_off;
    state_ff == utrovl_pkg::RS_RUN && trip |=> !out_en_ff;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("disable reaction left rail on");

  property p_hyst;
    ut_active_ff && ($signed({stage_temp[15], stage_temp}) < clear_lvl) |=> ut_active_ff;
  endproperty
  a_hyst: assert property (p_hyst) else $error("fault cleared inside hysteresis");

  property p_zero_delay;
    state_ff == utrovl_pkg::RS_WAIT && units_ff == 3'h0 && rail_ok |=> out_en_ff;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("retry not attempted");

  property p_timer_load;
    $rose(state_ff == utrovl_pkg::RS_WAIT) |-> step_ff == 24'h000000
      && units_ff == $past(delay_units);
  endproperty
  a_timer_load: assert property (p_timer_load) else $error("retry timer load wrong");

  property p_under_detect;
    !ut_active_ff && stage_temp < ut_limit |=> ut_active_ff;
  endproperty
  a_under_detect: assert property (p_under_detect) else $error("under-temp missed");

endmodule

//--- core/utrovl_top.sv
/*
  Management-port slave holding the paged under-temperature reaction and
  input-overvoltage threshold settings, fault flags and the alert line.
  Assumes the serial clock and data pins come from outside the clock domain.
*/
`timescale 1ns/1ns
module utrovl_top #(
  parameter int STEP_CYC = utrovl_pkg::RETRY_STEP_CYC
) (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      arst_n,
  // Management port pins
  input  wire logic                      scl_pin,
  input  wire logic                      sda_pin_in,
  output logic                           sda_pin_out_ff,
  output logic                           sda_pin_oe_ff,
  output logic                           bus_alert_line_n_out_ff,
  output logic                           bus_alert_line_n_oe_ff,
  // Measurements and limits
  input  wire logic signed [1:0][15:0]   stage_temp,
  input  wire logic signed [1:0][15:0]   undertemp_fault_threshold,
  input  wire logic        [15:0]        vin_meas,
  // Rail control
  input  wire logic        [1:0]         rail_on,
  input  wire logic                      bias_ok,
  input  wire logic        [1:0]         other_fault,
  output logic             [1:0]         rail_out_en,
  // Fault flags
  output logic             [1:0]         ut_flag_ff,
  output logic             [1:0]         ov_flag_ff
);

  logic                     scl_meta_ff, scl_sync_ff, scl_prev_ff;
  logic                     sda_meta_ff, sda_sync_ff, sda_prev_ff;
  logic                     scl_rise, scl_fall, bus_start, bus_stop;
  utrovl_pkg::utrovl_bus_e  bstate_ff, nxt_bstate;
  logic [7:0]               shreg_ff, nxt_shreg;
  logic [3:0]               bitcnt_ff, nxt_bitcnt;
  logic [1:0]               idx_ff, nxt_idx;
  logic                     addr_ff, nxt_addr;
  logic                     rd_ff, nxt_rd;
  logic                     nack_ff, nxt_nack;
  logic                     nxt_sda_oe;
  logic [7:0]               cmd_ff, nxt_cmd;
  logic [7:0]               lo_ff, nxt_lo;
  logic                     page_ff, nxt_page;
  logic [1:0][7:0]          react_ff, nxt_react;
  logic [1:0][15:0]         thr_ff, nxt_thr;
  logic [1:0]               nxt_ut_flag, nxt_ov_flag;
  logic                     clear_req;
  logic [1:0]               ut_active;
  logic [15:0]              rd_word;
  logic [7:0]               rd_byte;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second and third stages are looked at.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_meta_ff <= 1'b1;
      scl_sync_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_sync_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_meta_ff <= scl_pin;
      scl_sync_ff <= scl_meta_ff;
      scl_prev_ff <= scl_sync_ff;
      sda_meta_ff <= sda_pin_in;
      sda_sync_ff <= sda_meta_ff;
      sda_prev_ff <= sda_sync_ff;
    end
  end

  assign scl_rise  = scl_sync_ff && !scl_prev_ff;
  assign scl_fall  = !scl_sync_ff && scl_prev_ff;
  assign bus_start = scl_sync_ff && scl_prev_ff && sda_prev_ff && !sda_sync_ff;
  assign bus_stop  = scl_sync_ff && scl_prev_ff && !sda_prev_ff && sda_sync_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data for the selected command and page, low byte first.
  always_comb begin
    unique case (cmd_ff)
      utrovl_pkg::CMD_PAGE:     rd_word = {15'h0000, page_ff};
      utrovl_pkg::CMD_UT_REACT: rd_word = {8'h00, react_ff[page_ff]};
      utrovl_pkg::CMD_VIN_OV:   rd_word = thr_ff[page_ff];
      utrovl_pkg::CMD_STATUS: begin
        rd_word = 16'h0000;
        rd_word[utrovl_pkg::STAT_UT] = ut_flag_ff[page_ff];
        rd_word[utrovl_pkg::STAT_OV] = ov_flag_ff[page_ff];
      end
      default:                  rd_word = {8'h00, utrovl_pkg::RD_UNMAPPED};
    endcase
    rd_byte = (idx_ff == 2'h0) ? rd_word[7:0] : rd_word[15:8];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Byte engine and register writes.
  always_comb begin
    nxt_bstate = bstate_ff;
    nxt_shreg  = shreg_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_idx    = idx_ff;
    nxt_addr   = addr_ff;
    nxt_rd     = rd_ff;
    nxt_nack   = nack_ff;
    nxt_sda_oe = sda_pin_oe_ff;
    nxt_cmd    = cmd_ff;
    nxt_lo     = lo_ff;
    nxt_page   = page_ff;
    nxt_react  = react_ff;
    nxt_thr    = thr_ff;
    clear_req  = 1'b0;
    if (bus_start) begin
      nxt_bstate = utrovl_pkg::BS_RX;
      nxt_bitcnt = 4'h0;
      nxt_addr   = 1'b1;
      nxt_sda_oe = 1'b0;
    end else if (bus_stop) begin
      nxt_bstate = utrovl_pkg::BS_IDLE;
      nxt_sda_oe = 1'b0;
    end else begin
      unique case (bstate_ff)
        utrovl_pkg::BS_IDLE: ;
        utrovl_pkg::BS_RX: begin
          if (scl_rise && bitcnt_ff != utrovl_pkg::BYTE_BITS) begin
            nxt_shreg  = {shreg_ff[6:0], sda_sync_ff};
            nxt_bitcnt = bitcnt_ff + 4'h1;
          end else if (scl_fall && bitcnt_ff == utrovl_pkg::BYTE_BITS) begin
            nxt_bitcnt = 4'h0;
            nxt_bstate = utrovl_pkg::BS_ACK;
            nxt_sda_oe = 1'b1;
            if (addr_ff) begin
              nxt_addr = 1'b0;
              nxt_idx  = 2'h0;
              nxt_rd   = shreg_ff[0];
              if (shreg_ff[7:1] != utrovl_pkg::SLAVE_ADDR) begin
                nxt_bstate = utrovl_pkg::BS_IDLE;
                nxt_sda_oe = 1'b0;
              end
            end else begin
              if (idx_ff != 2'h3) begin
                nxt_idx = idx_ff + 2'h1;
              end
              unique case (idx_ff)
                2'h0: begin
                  nxt_cmd   = shreg_ff;
                  clear_req = (shreg_ff == utrovl_pkg::CMD_CLEAR);
                end
                2'h1: begin
                  nxt_lo = shreg_ff;
                  if (cmd_ff == utrovl_pkg::CMD_PAGE && shreg_ff < 8'(utrovl_pkg::PAGES)) begin
                    nxt_page = shreg_ff[0];
                  end
                  if (cmd_ff == utrovl_pkg::CMD_UT_REACT) begin
                    nxt_react[page_ff] = shreg_ff;
                  end
                end
                2'h2: begin
                  if (cmd_ff == utrovl_pkg::CMD_VIN_OV) begin
                    nxt_thr[page_ff] = {shreg_ff, lo_ff};
                  end
                end
                2'h3: ;
              endcase
            end
          end
        end
        utrovl_pkg::BS_ACK: begin
          if (scl_fall) begin
            if (rd_ff) begin
              nxt_bstate = utrovl_pkg::BS_TX;
              nxt_shreg  = rd_byte;
              nxt_sda_oe = !rd_byte[7];
              nxt_bitcnt = 4'h1;
            end else begin
              nxt_bstate = utrovl_pkg::BS_RX;
              nxt_sda_oe = 1'b0;
            end
          end
        end
        utrovl_pkg::BS_TX: begin
          if (scl_fall) begin
            if (bitcnt_ff == utrovl_pkg::BYTE_BITS) begin
              nxt_bstate = utrovl_pkg::BS_MACK;
              nxt_sda_oe = 1'b0;
            end else begin
              nxt_sda_oe = !shreg_ff[6];
              nxt_shreg  = {shreg_ff[6:0], 1'b0};
              nxt_bitcnt = bitcnt_ff + 4'h1;
            end
          end
        end
        utrovl_pkg::BS_MACK: begin
          if (scl_rise) begin
            nxt_nack = sda_sync_ff;
          end else if (scl_fall) begin
            if (nack_ff) begin
              nxt_bstate = utrovl_pkg::BS_IDLE;
            end else begin
              nxt_bstate = utrovl_pkg::BS_TX;
              nxt_idx    = (idx_ff == 2'h3) ? idx_ff : idx_ff + 2'h1;
              nxt_shreg  = rd_word[15:8];
              nxt_sda_oe = !rd_word[15];
              nxt_bitcnt = 4'h1;
            end
          end
        end
        default: nxt_bstate = utrovl_pkg::BS_IDLE;
      endcase
    end
    // Flags latch the fault level until a clear; a clear in the same cycle loses.
    for (int p = 0; p < utrovl_pkg::PAGES; p++) begin
      nxt_ut_flag[p] = (ut_flag_ff[p] && !clear_req) || ut_active[p];
      nxt_ov_flag[p] = (ov_flag_ff[p] && !clear_req) || (vin_meas > thr_ff[p]);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bstate_ff               <= utrovl_pkg::BS_IDLE;
      shreg_ff                <= 8'h00;
      bitcnt_ff               <= 4'h0;
      idx_ff                  <= 2'h0;
      addr_ff                 <= 1'b0;
      rd_ff                   <= 1'b0;
      nack_ff                 <= 1'b0;
      sda_pin_oe_ff           <= 1'b0;
      sda_pin_out_ff          <= 1'b0;
      cmd_ff                  <= 8'h00;
      lo_ff                   <= 8'h00;
      page_ff                 <= 1'b0;
      react_ff                <= {utrovl_pkg::PAGES{utrovl_pkg::UT_REACT_RST}};
      thr_ff                  <= {utrovl_pkg::PAGES{utrovl_pkg::VIN_OV_RST}};
      ut_flag_ff              <= 2'h0;
      ov_flag_ff              <= 2'h0;
      bus_alert_line_n_oe_ff  <= 1'b0;
      bus_alert_line_n_out_ff <= 1'b0;
    end else begin
      bstate_ff               <= nxt_bstate;
      shreg_ff                <= nxt_shreg;
      bitcnt_ff               <= nxt_bitcnt;
      idx_ff                  <= nxt_idx;
      addr_ff                 <= nxt_addr;
      rd_ff                   <= nxt_rd;
      nack_ff                 <= nxt_nack;
      sda_pin_oe_ff           <= nxt_sda_oe;
      sda_pin_out_ff          <= 1'b0;
      cmd_ff                  <= nxt_cmd;
      lo_ff                   <= nxt_lo;
      page_ff                 <= nxt_page;
      react_ff                <= nxt_react;
      thr_ff                  <= nxt_thr;
      ut_flag_ff              <= nxt_ut_flag;
      ov_flag_ff              <= nxt_ov_flag;
      bus_alert_line_n_oe_ff  <= |{nxt_ut_flag, nxt_ov_flag};
      bus_alert_line_n_out_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One reaction sequencer per page.
  for (genvar g = 0; g < utrovl_pkg::PAGES; g++) begin : g_page
    utrovl_retry #(
      .STEP_CYC (STEP_CYC)
    ) u_retry (
      .sys_clk      (sys_clk),
      .arst_n       (arst_n),
      .reaction     (react_ff[g]),
      .ut_limit     (undertemp_fault_threshold[g]),
      .stage_temp   (stage_temp[g]),
      .rail_on      (rail_on[g]),
      .bias_ok      (bias_ok),
      .other_fault  (other_fault[g]),
      .out_en_ff    (rail_out_en[g]),
      .ut_active_ff (ut_active[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_alert;
    $rose(ut_active[0]) |=> bus_alert_line_n_oe_ff && ut_flag_ff[0];
  endproperty
  a_alert: assert property (p_alert) else $error("alert not raised on fault");

  property p_ov_flag;
    vin_meas > thr_ff[1] |=> ov_flag_ff[1] && bus_alert_line_n_oe_ff;
  endproperty
  a_ov_flag: assert property (p_ov_flag) else $error("overvoltage flag missed");

  property p_clear_loses;
    clear_req && ut_active[0] |=> ut_flag_ff[0];
  endproperty
  a_clear_loses: assert property (p_clear_loses) else $error("clear beat a new fault");

endmodule

//--- testbench/utrovl_host.sv
/*
  Management-port host model: bit-level start, stop and byte tasks.
  Assumes an open-drain data wire with a pull-up resolved by the bench.
*/
`timescale 1ns/1ns
module utrovl_host (
  // Clock and resolved wire
  input  wire logic sys_clk,
  input  wire logic sda,
  // Driven pins
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Each bit is 8 core cycles, 320 ns; data moves only while the clock is low.
  task automatic bit_io(input logic b, output logic s);
    w(2);
    sda_low = !b;
    w(2);
    scl = 1'b1;
    w(2);
    s = sda;
    w(2);
    scl = 1'b0;
  endtask
  task automatic start();
    w(4);
    sda_low = 1'b0;
    w(2);
    scl = 1'b1;
    w(4);
    sda_low = 1'b1;
    w(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    w(4);
    sda_low = 1'b1;
    w(2);
    scl = 1'b1;
    w(4);
    sda_low = 1'b0;
    w(4);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(b[i], ack);
    bit_io(1'b1, ack);
  endtask
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, s);
  endtask
endmodule

//--- testbench/test_utrovl_top.sv
/*
  Self-checking bench for the reaction and threshold block.
  Assumes the host model drives the bus; STEP_CYC is shortened to 20.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_utrovl_top;
  logic                  sys_clk, arst_n, scl, sda_low, sda_oe, al_oe, sda_q, al_q;
  logic signed [1:0][15:0] temp, lim;
  logic [15:0]           vin, q;
  logic [1:0]            rail_on, oth, rail, utf, ovf;
  logic                  bias_ok;
  int                    errors, n_compared;
  wire                   sda = !(sda_low || sda_oe);
  utrovl_top #(.STEP_CYC(20)) i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .scl_pin(scl),
    .sda_pin_in(sda), .sda_pin_out_ff(sda_q), .sda_pin_oe_ff(sda_oe),
    .bus_alert_line_n_out_ff(al_q),
    .bus_alert_line_n_oe_ff(al_oe), .stage_temp(temp), .undertemp_fault_threshold(lim),
    .vin_meas(vin), .rail_on(rail_on), .bias_ok(bias_ok), .other_fault(oth),
    .rail_out_en(rail), .ut_flag_ff(utf), .ov_flag_ff(ovf));
  utrovl_host i_host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = !sys_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n);
    logic a;
    i_host.start();
    i_host.wbyte({utrovl_pkg::SLAVE_ADDR, 1'b0}, a);
    `CHK(a, 1'b0)
    i_host.wbyte(cmd, a);
    for (int i = 0; i < n; i++) i_host.wbyte(d[8*i+:8], a);
    i_host.stop();
  endtask
  task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] r);
    logic       a;
    logic [7:0] b;
    r = 16'h0000;
    i_host.start();
    i_host.wbyte({utrovl_pkg::SLAVE_ADDR, 1'b0}, a);
    i_host.wbyte(cmd, a);
    i_host.start();
    i_host.wbyte({utrovl_pkg::SLAVE_ADDR, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      i_host.rbyte(i == n - 1, b);
      r[8*i+:8] = b;
    end
    i_host.stop();
  endtask
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    final_report();
  end
  initial begin
    arst_n = 1'b0;
    temp = {16'sh0014, 16'sh0014};
    lim = '0;
    vin = 16'h0640;
    rail_on = 2'b11;
    bias_ok = 1'b1;
    oth = 2'b00;
    i_host.w(4);
    arst_n = 1'b1;
    i_host.w(4);
    rd(utrovl_pkg::CMD_UT_REACT, 1, q);
    `CHK(q, 16'h0084)
    rd(utrovl_pkg::CMD_VIN_OV, 2, q);
    `CHK(q, 16'h0640)
    wr(utrovl_pkg::CMD_VIN_OV, 16'hffff, 2);
    rd(utrovl_pkg::CMD_VIN_OV, 2, q);
    `CHK(q, 16'hffff)
    rd(utrovl_pkg::RD_UNMAPPED, 1, q);
    `CHK(q, 16'h00ff)
    wr(utrovl_pkg::CMD_PAGE, 16'h0001, 1);
    wr(utrovl_pkg::CMD_UT_REACT, 16'h0007, 1);
    rd(utrovl_pkg::CMD_UT_REACT, 1, q);
    `CHK(q, 16'h0007)
    wr(utrovl_pkg::CMD_PAGE, 16'h0000, 1);
    rd(utrovl_pkg::CMD_UT_REACT, 1, q);
    `CHK(q, 16'h0084)
    `CHK(ovf, 2'b00)
    vin = 16'h0641;
    i_host.w(4);
    `CHK(ovf, 2'b10)
    vin = 16'h0640;
    wr(utrovl_pkg::CMD_CLEAR, 16'h0000, 0);
    `CHK({ovf, al_oe}, 3'b000)
    `CHK({sda_q, al_q}, 2'b00)
    temp[0] = -16'sd1;
    i_host.w(4);
    `CHK({rail, utf, al_oe}, 5'b10011)
    temp[0] = 16'sd4;
    wr(utrovl_pkg::CMD_CLEAR, 16'h0000, 0);
    `CHK(utf, 2'b01)
    temp[0] = 16'sd5;
    wr(utrovl_pkg::CMD_CLEAR, 16'h0000, 0);
    `CHK({rail, utf}, 4'b1000)
    rail_on = 2'b00;
    i_host.w(4);
    rail_on = 2'b11;
    i_host.w(4);
    `CHK(rail, 2'b11)
    wr(utrovl_pkg::CMD_UT_REACT, 16'h00ba, 1);
    temp[0] = -16'sd1;
    i_host.w(4);
    `CHK(rail, 2'b10)
    temp[0] = 16'sd20;
    i_host.w(30);
    `CHK(rail, 2'b10)
    i_host.w(20);
    `CHK(rail, 2'b11)
    temp[0] = -16'sd1;
    i_host.w(4);
    oth = 2'b11;
    temp[0] = 16'sd20;
    i_host.w(60);
    `CHK(rail, 2'b00)
    oth = 2'b00;
    wr(utrovl_pkg::CMD_UT_REACT, 16'h00bf, 1);
    temp[0] = -16'sd1;
    i_host.w(4);
    temp[0] = 16'sd20;
    i_host.w(130);
    `CHK(rail, 2'b10)
    i_host.w(20);
    `CHK(rail, 2'b11)
    temp[0] = -16'sd1;
    i_host.w(4);
    bias_ok = 1'b0;
    temp[0] = 16'sd20;
    i_host.w(4);
    `CHK(rail, 2'b00)
    bias_ok = 1'b1;
    i_host.w(4);
    `CHK(rail, 2'b11)
    wr(utrovl_pkg::CMD_UT_REACT, 16'h0000, 1);
    lim = {16'sd30, -16'sd10};
    wr(utrovl_pkg::CMD_CLEAR, 16'h0000, 0);
    temp[0] = -16'sd11;
    i_host.w(4);
    `CHK({rail, utf}, 4'b1111)
    arst_n = 1'b0;
    i_host.w(4);
    `CHK({rail, utf, al_oe}, 5'b00000)
    arst_n = 1'b1;
    i_host.w(4);
    rd(utrovl_pkg::CMD_UT_REACT, 1, q);
    `CHK(q, 16'h0084)
    rd(utrovl_pkg::CMD_VIN_OV, 2, q);
    `CHK(q, 16'h0640)
    final_report();
  end
endmodule
